// *** test_uart_tx_rx_buffer_flags.sv ***
`timescale 1ns/1ps
`include "utxrx_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module test_uart_tx_rx_buffer_flags
    import utxrx_pkg::*;
;
    localparam logic [15:0] BAUD = 16'h0001;
    localparam int BIT = 16 * (int'(BAUD) + 1);
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, txc_irq_ack = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0, rd_q, wb_dat_o;
    logic wb_ack_o, serial_in_pin, serial_out_pin, serial_out_oe, xfer_clock_pin;
    logic rx_pin_owned, udre_irq, txc_irq, rxc_irq;
    int fail_count = 0;
    int tests_run = 0;
    always #2 clock = ~clock;
    utxrx_core #(.BAUD_RST(BAUD)) utxrx_core_inst (
        .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_in_pin(serial_in_pin),
        .xfer_clock_pin(xfer_clock_pin), .txc_irq_ack(txc_irq_ack),
        .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .rx_pin_owned(rx_pin_owned), .udre_irq(udre_irq),
        .txc_irq(txc_irq), .rxc_irq(rxc_irq)
    );
    utxrx_peer #(.BIT(BIT)) utxrx_peer_inst (
        .clock(clock), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
        .serial_in_pin(serial_in_pin), .xfer_clock_pin(xfer_clock_pin)
    );
    ////////////////////////////////////////////////////////////////
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (wb_ack_o === 1'b1) break;
        end
        `CHK("ack", 1'b1, wb_ack_o)
        rd_q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic poll(input int b, input logic v);
        for (int n = 0; n < 200; n++) begin
            wb(1'b0, `UTXRX_STATA_OFS, 32'h0);
            if (rd_q[b] === v) break;
        end
        `CHK("status bit", v, rd_q[b])
    endtask
    task automatic check_got(input logic [10:0] e);
        logic [10:0] g;
        for (int n = 0; n < 2000 && utxrx_peer_inst.got.size() == 0; n++) @(posedge clock);
        g = (utxrx_peer_inst.got.size() > 0) ? utxrx_peer_inst.got.pop_front() : 11'h7ff;
        `CHK("tx frame", e, g)
    endtask
    // clears the complete flag afterwards so the next poll sees a fresh set
    task automatic tx_frame(input logic [7:0] d, input logic [10:0] e);
        wb(1'b1, `UTXRX_DATA_OFS, {24'h0, d});
        check_got(e);
        poll(`UTXRX_A_TXC, 1'b1);
        wb(1'b1, `UTXRX_STATA_OFS, 32'h40);
        poll(`UTXRX_A_TXC, 1'b0);
    endtask
    task automatic end_sim;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        `CHK("oe", 1'b0, serial_out_oe)
        wb(1'b0, `UTXRX_STATA_OFS, 32'h0);
        `CHK("status", 32'h20, rd_q)
        wb(1'b0, `UTXRX_CTRLC_OFS, 32'h0);
        `CHK("ctrl_c", {24'h0, `UTXRX_CTRLC_RST}, rd_q)
        wb(1'b0, `UTXRX_BAUD_OFS, 32'h0);
        `CHK("baud", {16'h0, BAUD}, rd_q)
        wb(1'b1, 8'h14, 32'hff);
        wb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", 32'h0, rd_q)
        wb(1'b1, `UTXRX_CTRLB_OFS, 32'hf8);
        repeat (2) @(negedge clock);
        `CHK("rx owned", 1'b1, rx_pin_owned)
        `CHK("oe", 1'b1, serial_out_oe)
        `CHK("udre irq", 1'b1, udre_irq)
        // second byte must wait in the buffer behind the first
        wb(1'b1, `UTXRX_DATA_OFS, 32'ha5);
        wb(1'b1, `UTXRX_DATA_OFS, 32'h3c);
        wb(1'b0, `UTXRX_STATA_OFS, 32'h0);
        `CHK("udre", 1'b0, rd_q[`UTXRX_A_UDRE])
        check_got(11'h1a5);
        check_got(11'h13c);
        poll(`UTXRX_A_TXC, 1'b1);
        repeat (2) @(negedge clock);
        `CHK("txc irq", 1'b1, txc_irq)
        @(posedge clock) txc_irq_ack <= 1'b1;
        @(posedge clock) txc_irq_ack <= 1'b0;
        wb(1'b0, `UTXRX_STATA_OFS, 32'h0);
        `CHK("txc", 1'b0, rd_q[`UTXRX_A_TXC])
        `CHK("udre", 1'b1, rd_q[`UTXRX_A_UDRE])
        utxrx_peer_inst.pen = 1'b1;
        for (int odd = 0; odd < 2; odd++) begin
            wb(1'b1, `UTXRX_CTRLC_OFS, 32'h26 | (odd << 4));
            tx_frame(8'h07, {2'b01, 1'b1 ^ odd[0], 8'h07});
        end
        utxrx_peer_inst.pen = 1'b0;
        // two stops selected; the peer starts its next frame right after the first
        wb(1'b1, `UTXRX_CTRLC_OFS, 32'h0e);
        utxrx_peer_inst.send(9'h05a, 8);
        poll(`UTXRX_A_RXC, 1'b1);
        `CHK("rxc irq", 1'b1, rxc_irq)
        wb(1'b0, `UTXRX_DATA_OFS, 32'h0);
        `CHK("rx data", 32'h5a, rd_q)
        poll(`UTXRX_A_RXC, 1'b0);
        utxrx_peer_inst.send(9'h011, 8);
        utxrx_peer_inst.send(9'h022, 8);
        wb(1'b0, `UTXRX_DATA_OFS, 32'h0);
        `CHK("rx first", 32'h11, rd_q)
        wb(1'b0, `UTXRX_DATA_OFS, 32'h0);
        `CHK("rx second", 32'h22, rd_q)
        wb(1'b1, `UTXRX_CTRLC_OFS, 32'h00);
        utxrx_peer_inst.send(9'h1ff, 5);
        poll(`UTXRX_A_RXC, 1'b1);
        wb(1'b0, `UTXRX_DATA_OFS, 32'h0);
        `CHK("rx short", 32'h1f, rd_q)
        wb(1'b1, `UTXRX_CTRLC_OFS, 32'h46);
        wb(1'b1, `UTXRX_CTRLB_OFS, 32'hfc);
        utxrx_peer_inst.send(9'h1a5, 9);
        poll(`UTXRX_A_RXC, 1'b1);
        wb(1'b0, `UTXRX_CTRLB_OFS, 32'h0);
        `CHK("rx ninth", 1'b1, rd_q[`UTXRX_B_RXB8])
        wb(1'b0, `UTXRX_DATA_OFS, 32'h0);
        `CHK("rx nine data", 32'ha5, rd_q)
        wb(1'b1, `UTXRX_CTRLC_OFS, 32'h06);
        utxrx_peer_inst.nbits = 9;
        wb(1'b1, `UTXRX_CTRLB_OFS, 32'hfd);
        tx_frame(8'h3c, 11'h33c);
        utxrx_peer_inst.nbits = 8;
        wb(1'b1, `UTXRX_CTRLB_OFS, 32'hf8);
        wb(1'b1, `UTXRX_DATA_OFS, 32'h81);
        wb(1'b1, `UTXRX_DATA_OFS, 32'h42);
        wb(1'b1, `UTXRX_CTRLB_OFS, 32'hf0);
        @(negedge clock);
        `CHK("oe held", 1'b1, serial_out_oe)
        check_got(11'h181);
        check_got(11'h142);
        poll(`UTXRX_A_TXC, 1'b1);
        repeat (4) @(negedge clock);
        `CHK("oe released", 1'b0, serial_out_oe)
        wb(1'b1, `UTXRX_CTRLB_OFS, 32'h00);
        repeat (2) @(negedge clock);
        `CHK("rx released", 1'b0, rx_pin_owned)
        end_sim();
    end
endmodule // test_uart_tx_rx_buffer_flags

// *** utxrx_core.sv ***
// Behaviour
// - buffer-empty flag high when transmit buffer empty, low while data waits
// - buffer-empty irq stays high while flag and its enable are set
// - writing data port while transmitter enabled loads transmit buffer and clears buffer-empty flag
// - complete flag sets when frame shifted out and buffer empty
// - complete flag clears on irq acknowledge or written one
// - complete irq raised when complete flag set and enabled
// - parity bit inserted after data, before first stop, when enabled
// - clearing transmit enable waits until shifter and buffer are empty
// - serial output released to port once transmitter is disabled
// - receive enable takes over serial input pin
// - synchronous mode receives on external transfer clock rising edges
// - receiver starts on valid start bit, shifts bits until first stop
// - second stop bit is ignored and not checked
// - first stop bit moves frame into receive buffer
// - short characters read with zero upper bits
// - ninth bit and error flags stored per fifo entry, advanced by read
// - receive complete flag high while unread data is buffered
// - frame is start bit then data least significant bit first
// - parity is xor of data bits, inverted for odd
`timescale 1ns/1ps
`include "utxrx_params.svh"
module utxrx_core
    import utxrx_pkg::*;
#(
    parameter logic [15:0] BAUD_RST = `UTXRX_BAUD_RST
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_in_pin,
    input wire logic xfer_clock_pin,
    input wire logic txc_irq_ack,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic rx_pin_owned,
    output logic udre_irq,
    output logic txc_irq,
    output logic rxc_irq
);
    ////////////////////////////////////////////////////////////////
    // registers
    logic ack_q;
    logic [7:0] ctrl_b_q;
    logic [7:0] ctrl_c_q;
    logic [15:0] baud_q;
    utxrx_fmt_t fmt;
    logic bus_req;
    logic wr_data;
    logic rd_data;
    logic wr_stata;
    logic txc_flag_q;
    logic [8:0] tx_buf_q;
    logic tx_buf_full_q;
    logic tx_active_q;
    logic tx_enable_eff_q;
    logic [11:0] tx_shift_q;
    logic [3:0] tx_bits_left_q;
    logic [15:0] tx_baud_cnt_q;
    logic [3:0] tx_div_q;
    logic tx_tick;
    logic tx_load;
    logic tx_done;
    utxrx_rx_entry_t rx_head;
    logic rx_not_empty;
    logic rx_full;
    logic [7:0] rd_mux;

    function automatic logic [3:0] data_bits(input logic [2:0] cs);
        data_bits = (cs == 3'h7) ? 4'h9 : {2'b00, cs[1:0]} + 4'h5;
    endfunction

    function automatic logic calc_par(input logic [8:0] d, input logic [3:0] n,
                                      input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                p = p ^ d[i];
            end
        end
        calc_par = p;
    endfunction

    assign fmt.char_size = {ctrl_b_q[`UTXRX_B_UCSZ2], ctrl_c_q[`UTXRX_C_CSZ_HI],
                            ctrl_c_q[`UTXRX_C_CSZ_LO]};
    assign fmt.parity_en = ctrl_c_q[`UTXRX_C_PEN];
    assign fmt.parity_odd = ctrl_c_q[`UTXRX_C_PODD];
    assign fmt.two_stop = ctrl_c_q[`UTXRX_C_STOP2];
    assign fmt.sync_mode = ctrl_c_q[`UTXRX_C_SYNC];

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_data = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `UTXRX_DATA_OFS);
    assign rd_data = bus_req && !wb_we_i && (wb_adr_i == `UTXRX_DATA_OFS);
    assign wr_stata = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `UTXRX_STATA_OFS);

    ////////////////////////////////////////////////////////////////
    // wishbone slave, one wait state free answer after one cycle
    always_comb begin
        rd_mux = 8'h00;
        unique case (wb_adr_i)
            `UTXRX_DATA_OFS: rd_mux = (data_bits(fmt.char_size) >= 4'h8) ? rx_head.data :
                rx_head.data & ~(8'hff << data_bits(fmt.char_size));
            `UTXRX_STATA_OFS: rd_mux = {rx_not_empty, txc_flag_q, !tx_buf_full_q,
                rx_head.frame_err, rx_head.overrun, rx_head.parity_err, 2'b00};
            `UTXRX_CTRLB_OFS: rd_mux = {ctrl_b_q[7:2], rx_head.ninth, ctrl_b_q[0]};
            `UTXRX_CTRLC_OFS: rd_mux = ctrl_c_q;
            `UTXRX_BAUD_OFS: rd_mux = baud_q[7:0];
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_q <= bus_req;
            wb_dat_o <= (wb_adr_i == `UTXRX_BAUD_OFS) ? {16'h0, baud_q} : {24'h0, rd_mux};
        end
    end
    assign wb_ack_o = ack_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_b_q <= 8'h00;
            ctrl_c_q <= `UTXRX_CTRLC_RST;
            baud_q <= BAUD_RST;
        end else if (bus_req && wb_we_i) begin
            if (wb_adr_i == `UTXRX_CTRLB_OFS && wb_sel_i[0]) begin
                ctrl_b_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `UTXRX_CTRLC_OFS && wb_sel_i[0]) begin
                ctrl_c_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `UTXRX_BAUD_OFS) begin
                if (wb_sel_i[0]) baud_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) baud_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // transmitter: bit tick from baud divider or external clock
    logic xck_prev_q;
    logic xck_rise;
    logic xck_fall;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            xck_prev_q <= 1'b0;
        end else begin
            xck_prev_q <= xfer_clock_pin;
        end
    end
    assign xck_rise = xfer_clock_pin && !xck_prev_q;
    assign xck_fall = !xfer_clock_pin && xck_prev_q;

    always_ff @(posedge clock) begin
        if (!rst_n || !tx_active_q) begin
            tx_baud_cnt_q <= 16'h0;
            tx_div_q <= 4'h0;
        end else if (tx_baud_cnt_q == baud_q) begin
            tx_baud_cnt_q <= 16'h0;
            tx_div_q <= tx_div_q + 4'h1;
        end else begin
            tx_baud_cnt_q <= tx_baud_cnt_q + 16'h1;
        end
    end
    // sync mode drives data on falling edge so peer samples on the rise
    assign tx_tick = fmt.sync_mode ? xck_fall :
        ((tx_baud_cnt_q == baud_q) && (tx_div_q == 4'hf));

    assign tx_load = tx_buf_full_q && (!tx_active_q || tx_done);
    assign tx_done = tx_active_q && tx_tick && (tx_bits_left_q == 4'h1);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_buf_full_q <= 1'b0;
            tx_buf_q <= 9'h0;
        end else if (wr_data && tx_enable_eff_q) begin
            tx_buf_full_q <= 1'b1;
            tx_buf_q <= {ctrl_b_q[`UTXRX_B_TX_NINTH], wb_dat_i[7:0]};
        end else if (tx_load) begin
            tx_buf_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_active_q <= 1'b0;
            tx_shift_q <= 12'hfff;
            tx_bits_left_q <= 4'h0;
        end else if (tx_load) begin
            tx_active_q <= 1'b1;
            // frame: start, data lsb first, parity, stop(s); idle ones beyond
            tx_shift_q <= build_frame(tx_buf_q);
            tx_bits_left_q <= 4'h2 + data_bits(fmt.char_size) +
                4'(fmt.parity_en) + 4'(fmt.two_stop);
        end else if (tx_done) begin
            tx_active_q <= 1'b0;
            tx_shift_q <= 12'hfff;
        end else if (tx_active_q && tx_tick) begin
            tx_shift_q <= {1'b1, tx_shift_q[11:1]};
            tx_bits_left_q <= tx_bits_left_q - 4'h1;
        end
    end

    function automatic logic [11:0] build_frame(input logic [8:0] d);
        logic [11:0] f;
        logic [3:0] n;
        f = 12'hfff;
        n = data_bits(fmt.char_size);
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                f[i + 1] = d[i];
            end
        end
        if (fmt.parity_en) begin
            f[n + 4'h1] = calc_par(d, n, fmt.parity_odd);
        end
        build_frame = f;
    endfunction

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txc_flag_q <= 1'b0;
        end else if (tx_done && !tx_buf_full_q) begin
            txc_flag_q <= 1'b1;
        end else if (txc_irq_ack || (wr_stata && wb_dat_i[`UTXRX_A_TXC])) begin
            txc_flag_q <= 1'b0;
        end
    end

    // disable only once nothing is left to send
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_enable_eff_q <= 1'b0;
        end else if (ctrl_b_q[`UTXRX_B_TX_ON]) begin
            tx_enable_eff_q <= 1'b1;
        end else if (!tx_active_q && !tx_buf_full_q) begin
            tx_enable_eff_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            serial_out_pin <= 1'b1;
            serial_out_oe <= 1'b0;
            rx_pin_owned <= 1'b0;
        end else begin
            serial_out_pin <= tx_shift_q[0];
            serial_out_oe <= tx_enable_eff_q;
            rx_pin_owned <= ctrl_b_q[`UTXRX_B_RXEN];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            udre_irq <= 1'b0;
            txc_irq <= 1'b0;
            rxc_irq <= 1'b0;
        end else begin
            udre_irq <= !tx_buf_full_q && ctrl_b_q[`UTXRX_B_UDRIE];
            txc_irq <= txc_flag_q && ctrl_b_q[`UTXRX_B_TXCIE];
            rxc_irq <= rx_not_empty && ctrl_b_q[`UTXRX_B_RXCIE];
        end
    end

    ////////////////////////////////////////////////////////////////
    // receiver: mid-bit sampling, 16 ticks per bit async
    utxrx_state_t rx_state_q;
    logic rx_en;
    logic [15:0] rx_baud_cnt_q;
    logic [3:0] rx_phase_q;
    logic rx_sample;
    logic [8:0] rx_shift_q;
    logic [3:0] rx_cnt_q;
    logic rx_par_q;
    logic rx_overrun_q;
    logic rx_push;
    utxrx_rx_entry_t rx_entry;

    assign rx_en = ctrl_b_q[`UTXRX_B_RXEN];
    always_ff @(posedge clock) begin
        if (!rst_n || rx_state_q == UTXRX_IDLE || rx_baud_cnt_q == baud_q) begin
            rx_baud_cnt_q <= 16'h0;
        end else begin
            rx_baud_cnt_q <= rx_baud_cnt_q + 16'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n || rx_state_q == UTXRX_IDLE) begin
            rx_phase_q <= 4'h0;
        end else if (rx_baud_cnt_q == baud_q) begin
            rx_phase_q <= rx_phase_q + 4'h1;
        end
    end
    assign rx_sample = fmt.sync_mode ? xck_rise :
        ((rx_baud_cnt_q == baud_q) && (rx_phase_q == 4'h7));

    always_ff @(posedge clock) begin
        if (!rst_n || !rx_en) begin
            rx_state_q <= UTXRX_IDLE;
            rx_cnt_q <= 4'h0;
            rx_shift_q <= 9'h0;
            rx_par_q <= 1'b0;
        end else begin
            unique case (rx_state_q)
                UTXRX_IDLE: if (!serial_in_pin) begin
                    rx_state_q <= UTXRX_START;
                end
                UTXRX_START: if (rx_sample) begin
                    // false start filtered at mid-bit
                    rx_state_q <= serial_in_pin ? UTXRX_IDLE : UTXRX_BITS;
                    rx_cnt_q <= 4'h0;
                    rx_shift_q <= 9'h0;
                end
                UTXRX_BITS: if (rx_sample) begin
                    if (rx_cnt_q < data_bits(fmt.char_size)) begin
                        rx_shift_q[rx_cnt_q] <= serial_in_pin;
                    end else begin
                        rx_par_q <= serial_in_pin;
                    end
                    rx_cnt_q <= rx_cnt_q + 4'h1;
                    if (rx_cnt_q + 4'h1 == data_bits(fmt.char_size) + 4'(fmt.parity_en)) begin
                        rx_state_q <= UTXRX_STOP;
                    end
                end
                // return to idle after first stop; second stop looks idle
                UTXRX_STOP: if (rx_sample) begin
                    rx_state_q <= UTXRX_IDLE;
                end
            endcase
        end
    end

    assign rx_push = (rx_state_q == UTXRX_STOP) && rx_sample && rx_en;
    assign rx_entry.ninth = rx_shift_q[8];
    assign rx_entry.data = rx_shift_q[7:0];
    assign rx_entry.frame_err = !serial_in_pin;
    assign rx_entry.overrun = rx_overrun_q;
    assign rx_entry.parity_err = fmt.parity_en &&
        (rx_par_q != calc_par(rx_shift_q, data_bits(fmt.char_size), fmt.parity_odd));

    // overrun: new start while fifo full; flag rides with next stored frame
    always_ff @(posedge clock) begin
        if (!rst_n || !rx_en) begin
            rx_overrun_q <= 1'b0;
        end else if (rx_state_q == UTXRX_IDLE && !serial_in_pin && rx_full) begin
            rx_overrun_q <= 1'b1;
        end else if (rx_push && !rx_full) begin
            rx_overrun_q <= 1'b0;
        end
    end

    utxrx_rx_fifo #(
        .DEPTH(`UTXRX_RX_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .flush(!rx_en),
        .push(rx_push),
        .push_entry(rx_entry),
        .pop(rd_data),
        .head(rx_head),
        .not_empty(rx_not_empty),
        .full(rx_full)
    );
endmodule // utxrx_core

// *** utxrx_core_sva.sv ***
`timescale 1ns/1ps
module utxrx_core_chk
    import utxrx_pkg::*;
#(
    parameter logic [15:0] BAUD_RST = 16'h0001
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    input wire logic rx_pin_owned,
    input wire logic txc_irq,
    input wire logic rxc_irq
);
    localparam int BIT = 16 * (int'(BAUD_RST) + 1);
    logic prev_q;
    logic [15:0] run_q;
    ////////////////////////////////////////////////////////////////
    // length of the present level on the tx line, saturating
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prev_q <= 1'b1;
            run_q <= 16'h0000;
        end else begin
            prev_q <= serial_out_pin;
            if (serial_out_pin != prev_q) begin
                run_q <= 16'h0001;
            end else if (run_q != 16'hffff) begin
                run_q <= run_q + 16'h0001;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_after_take: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_idle_high: assert property (!serial_out_oe |-> serial_out_pin)
        else $error("tx line low while released");
    a_start_owned: assert property ($fell(serial_out_pin) |-> serial_out_oe)
        else $error("frame started without owning the pin");
    // low runs are whole bits: start plus zero data bits
    a_low_run_whole: assert property ($rose(serial_out_pin) |-> (run_q % BIT) == 0)
        else $error("low level not a whole number of bits");
    // half a bit of margin: exact flag latency is the design's choice
    a_release_late: assert property ($fell(serial_out_oe) |-> run_q >= BIT / 2)
        else $error("pin released before stop bit went out");
    a_txc_after_stop: assert property ($rose(txc_irq) |-> serial_out_pin && run_q >= BIT / 2)
        else $error("complete raised before frame finished");
    a_rxc_owned: assert property (rxc_irq |-> $past(rx_pin_owned))
        else $error("receive irq with receiver disabled");
endmodule // utxrx_core_chk

bind utxrx_core utxrx_core_chk #(.BAUD_RST(BAUD_RST)) utxrx_core_chk_inst (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .rx_pin_owned(rx_pin_owned), .txc_irq(txc_irq), .rxc_irq(rxc_irq)
);

// *** utxrx_params.svh ***
`ifndef UTXRX_PARAMS_SVH
`define UTXRX_PARAMS_SVH
// register byte offsets
`define UTXRX_DATA_OFS 8'h00
`define UTXRX_STATA_OFS 8'h04
`define UTXRX_CTRLB_OFS 8'h08
`define UTXRX_CTRLC_OFS 8'h0c
`define UTXRX_BAUD_OFS 8'h10
// status_reg_a bits
`define UTXRX_A_RXC 7
`define UTXRX_A_TXC 6
`define UTXRX_A_UDRE 5
`define UTXRX_A_FE 4
`define UTXRX_A_DOR 3
`define UTXRX_A_UPE 2
// control_reg_b bits
`define UTXRX_B_RXCIE 7
`define UTXRX_B_TXCIE 6
`define UTXRX_B_UDRIE 5
`define UTXRX_B_RXEN 4
`define UTXRX_B_TX_ON 3
`define UTXRX_B_UCSZ2 2
`define UTXRX_B_RXB8 1
`define UTXRX_B_TX_NINTH 0
// control_reg_c bits
`define UTXRX_C_SYNC 6
`define UTXRX_C_PEN 5
`define UTXRX_C_PODD 4
`define UTXRX_C_STOP2 3
`define UTXRX_C_CSZ_HI 2
`define UTXRX_C_CSZ_LO 1
// reset values and receive fifo depth
`define UTXRX_CTRLC_RST 8'h06
`define UTXRX_BAUD_RST 16'h0067
`define UTXRX_RX_DEPTH 2
`endif

// *** utxrx_peer.sv ***
`timescale 1ns/1ps
module utxrx_peer
    import utxrx_pkg::*;
#(
    parameter int BIT = 32
) (
    input wire logic clock,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    output logic xfer_clock_pin,
    output logic serial_in_pin
);
    int nbits = 8;
    logic pen = 1'b0;
    logic [10:0] got[$];
    logic [10:0] f;
    initial {serial_in_pin, xfer_clock_pin} = 2'b10;
    ////////////////////////////////////////////////////////////////
    // clock rises mid-bit, rests low between frames; no idle after the stop bit
    task automatic send(input logic [8:0] d, input int n);
        logic [10:0] s;
        s = {1'b1, d, 1'b0} | (11'h7ff << (n + 1));
        for (int i = 0; i <= n + 1; i++) begin
            serial_in_pin <= s[i];
            repeat (BIT / 2) @(posedge clock);
            xfer_clock_pin <= 1'b1;
            repeat (BIT / 2) @(posedge clock);
            xfer_clock_pin <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // mid-bit sampling; keeps data, parity and first stop bit
    always begin
        @(negedge serial_out_pin);
        if (serial_out_oe) begin
            f = '0;
            repeat (BIT / 2) @(posedge clock);
            for (int i = 0; i <= nbits + int'(pen); i++) begin
                repeat (BIT) @(posedge clock);
                f[i] = serial_out_pin;
            end
            got.push_back(f);
        end
    end
endmodule // utxrx_peer

// *** utxrx_pkg.sv ***
package utxrx_pkg;
    typedef struct packed {
        logic ninth;
        logic frame_err;
        logic overrun;
        logic parity_err;
        logic [7:0] data;
    } utxrx_rx_entry_t;
    typedef enum logic [3:0] {
        UTXRX_IDLE = 4'b0001,
        UTXRX_START = 4'b0010,
        UTXRX_BITS = 4'b0100,
        UTXRX_STOP = 4'b1000
    } utxrx_state_t;
    typedef struct packed {
        logic [2:0] char_size;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic sync_mode;
    } utxrx_fmt_t;
endpackage

// *** utxrx_rx_fifo.sv ***
`timescale 1ns/1ps
`include "utxrx_params.svh"
module utxrx_rx_fifo
    import utxrx_pkg::*;
#(
    parameter int DEPTH = `UTXRX_RX_DEPTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic push,
    input wire utxrx_rx_entry_t push_entry,
    input wire logic pop,
    output utxrx_rx_entry_t head,
    output logic not_empty,
    output logic full
);
    utxrx_rx_entry_t mem [DEPTH];
    logic [$clog2(DEPTH):0] count_q;
    logic [$clog2(DEPTH)-1:0] rd_q;
    logic [$clog2(DEPTH)-1:0] wr_q;
    logic do_push;
    logic do_pop;

    function automatic logic [$clog2(DEPTH)-1:0] nxt(input logic [$clog2(DEPTH)-1:0] p);
        nxt = (p == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign do_pop = pop && (count_q != '0);
    assign do_push = push && ((count_q != ($clog2(DEPTH)+1)'(DEPTH)) || do_pop);
    // empty head reads zero: no unwritten or stale entry leaks into status
    assign head = not_empty ? mem[rd_q] : '0;
    assign not_empty = (count_q != '0);
    assign full = (count_q == ($clog2(DEPTH)+1)'(DEPTH));

    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_q] <= push_entry;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || flush) begin
            count_q <= '0;
            rd_q <= '0;
            wr_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= nxt(wr_q);
            end
            if (do_pop) begin
                rd_q <= nxt(rd_q);
            end
            count_q <= count_q + (($clog2(DEPTH)+1)'(do_push)) - (($clog2(DEPTH)+1)'(do_pop));
        end
    end
endmodule // utxrx_rx_fifo
